// file: core/pdsp_pkg.sv
/*
  pdsp_pkg: constants and types shared by the duty-to-stepper positioner
  and its divider. Assumes a 100 MHz clock on ref_clk_i.
*/
package pdsp_pkg;

  // clock figures
  localparam int unsigned CLK_PERIOD_NS = 10;

  // capture counter and index widths
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned IDX_W         = 7;
  localparam int unsigned DIVIDEND_W    = CNT_W + IDX_W;
  localparam int unsigned TMR_W         = 24;

  // homing and positioning figures
  localparam logic [IDX_W-1:0] HOME_MOVES   = 7'd100;
  localparam logic [IDX_W-1:0] START_POS    = 7'd0;
  localparam logic [IDX_W-1:0] FULL_SCALE   = 7'd100;
  localparam logic [IDX_W-1:0] PERCENT_MULT = 7'd100;
  localparam int unsigned      IDLE_LIMIT   = 5000;

  // delay routine: wait after each coil pattern, cycles derived from the time
  localparam int unsigned STEP_DELAY_NS  = 1000000;
  localparam int unsigned STEP_DELAY_CYC =
    (STEP_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (STEP_DELAY_NS / CLK_PERIOD_NS);

  // coil patterns {a_pos, a_neg, b_pos, b_neg}, phase 0 in the low nibble
  localparam logic [3:0]  COIL_OFF    = 4'h0;
  localparam logic [19:0] PAT_FORWARD = {4'h0, 4'h6, 4'h5, 4'h9, 4'ha};
  localparam logic [19:0] PAT_REVERSE = {4'h0, 4'h9, 4'h5, 4'h6, 4'ha};
  localparam logic [2:0]  LAST_PHASE  = 3'd4;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_RST = 24'h000000;

  // main sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_MOVE    = 8'h01,
    ST_ARM     = 8'h02,
    ST_PERIOD  = 8'h04,
    ST_HIGH    = 8'h08,
    ST_CALC    = 8'h10,
    ST_COMPARE = 8'h20,
    ST_IDLE    = 8'h40,
    ST_SPARE   = 8'h80
  } pdsp_state_t;

  // divider states, one-hot
  typedef enum logic [1:0] {
    DV_IDLE = 2'b01,
    DV_RUN  = 2'b10
  } pdsp_dv_state_t;

endpackage

// file: core/pdsp_divider.sv
/*
  pdsp_divider: sequential restoring divider, one quotient bit per clock.
  Assumes start_i is a one-cycle pulse with the divisor not zero.
*/
`timescale 1ns/1ns
module pdsp_divider
  import pdsp_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  start_i,
  input  wire logic [DIVIDEND_W-1:0] dividend_i,
  input  wire logic [CNT_W-1:0]      divisor_i,
  output logic      [DIVIDEND_W-1:0] quot_o,
  output logic                       done_o
);

  typedef struct packed {
    pdsp_dv_state_t        st;
    logic [4:0]            bits;
    logic [CNT_W:0]        rem;
    logic [DIVIDEND_W-1:0] quo;
    logic [CNT_W-1:0]      dsr;
    logic                  done;
  } pdsp_dv_t;

  pdsp_dv_t q;
  pdsp_dv_t d;
  logic [CNT_W:0] trial;

  // one shift-and-subtract step per cycle
  always_comb begin
    d      = q;
    d.done = 1'b0;
    trial  = {q.rem[CNT_W-1:0], q.quo[DIVIDEND_W-1]};
    case (q.st)
      DV_IDLE: begin
        if (start_i) begin
          d.st   = DV_RUN;
          d.bits = 5'(DIVIDEND_W);
          d.rem  = '0;
          d.quo  = dividend_i;
          d.dsr  = divisor_i;
        end
      end
      DV_RUN: begin
        d.quo = {q.quo[DIVIDEND_W-2:0], 1'b0};
        if (trial >= {1'b0, q.dsr}) begin
          d.rem    = trial - {1'b0, q.dsr};
          d.quo[0] = 1'b1;
        end else begin
          d.rem = trial;
        end
        d.bits = q.bits - 5'd1;
        if (q.bits == 5'd1) begin
          d.st   = DV_IDLE;
          d.done = 1'b1;
        end
      end
      default: d.st = DV_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{st: DV_IDLE, bits: 5'd0, rem: '0, quo: '0, dsr: '0, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign quot_o = q.quo;
  assign done_o = q.done;

endmodule

// file: core/pdsp_positioner.sv
/*
  pdsp_positioner: measures an incoming PWM, converts its duty to a gauge
  index 0..100 and steps a bipolar stepper there through the coil port.
  Assumes one clock at 100 MHz, a synchronous active-low reset, a PWM pin
  that is asynchronous to the clock, and coils wired as {a_pos,a_neg,b_pos,b_neg}.
*/
// How it works
// - new duty sets target, motor driven there
// - forward coils cycle 0a,09,05,06
// - backward coils cycle 0a,06,05,09
// - one pattern change per step interval
// - home 100 backward moves, then index zero
// - rise arms count, next rise latches period
// - then falling edge latches high time
// - target equals high times 100 over period
// - one measurement serves every decision until idle expires
// - finished measurement sets measured flag
// - equal indices: idle 5000 counts, remeasure
// - direction from comparing target and present
// - forward moves increment index until equal
// - forward move ends with coils off
// - fixed delay after every coil pattern
// - backward moves decrement index, end coils off
// - after match, idle expiry clears flag, loop forever
`timescale 1ns/1ns
module pdsp_positioner
  import pdsp_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT_CYC = IDLE_LIMIT,
  parameter int unsigned STEP_DLY_CYC   = STEP_DELAY_CYC
)(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             capture_channel_input_i,
  output logic      [3:0]       coil_drive_port_o,
  output logic      [IDX_W-1:0] present_index_o,
  output logic      [IDX_W-1:0] target_index_o,
  output logic                  measured_o,
  output logic                  homing_o
);

  typedef struct packed {
    pdsp_state_t      st;
    logic             pwm_s1;
    logic             pwm_s2;
    logic             pwm_s3;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high;
    logic [IDX_W-1:0] target;
    logic [IDX_W-1:0] present;
    logic             measured;
    logic             dir_fwd;
    logic             homing;
    logic [IDX_W-1:0] home_cnt;
    logic [2:0]       phase;
    logic [TMR_W-1:0] tmr;
    logic [3:0]       coil;
    logic             div_start;
  } pdsp_core_t;

  localparam logic [TMR_W-1:0] STEP_DLY  = TMR_W'(STEP_DLY_CYC);
  localparam logic [TMR_W-1:0] IDLE_LAST = TMR_W'(IDLE_LIMIT_CYC - 1);

  pdsp_core_t            q;
  pdsp_core_t            d;
  logic                  rise;
  logic                  fall;
  logic [CNT_W-1:0]      cnt_inc;
  logic [DIVIDEND_W-1:0] quot;
  logic                  div_done;
  logic [19:0]           pat_tbl;
  logic [DIVIDEND_W-1:0] dividend;

  // dividend widened before the product so no bit of high*100 is lost
  assign dividend = DIVIDEND_W'(q.high) * DIVIDEND_W'(PERCENT_MULT);

  // percentage division, high*100/period
  pdsp_divider u_div (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (q.div_start),
    .dividend_i (dividend),
    .divisor_i  (q.period),
    .quot_o     (quot),
    .done_o     (div_done)
  );

  // edge detect reads only the second and third sync stages
  assign rise    = q.pwm_s2 & ~q.pwm_s3;
  assign fall    = ~q.pwm_s2 & q.pwm_s3;
  assign cnt_inc = (q.cnt == '1) ? q.cnt : q.cnt + CNT_W'(1);
  assign pat_tbl = q.dir_fwd ? PAT_FORWARD : PAT_REVERSE;

  // sequencer: homing, measure, compare, move, idle
  always_comb begin
    d           = q;
    d.pwm_s1    = capture_channel_input_i;
    d.pwm_s2    = q.pwm_s1;
    d.pwm_s3    = q.pwm_s2;
    d.div_start = 1'b0;
    case (q.st)
      ST_MOVE: begin
        if (q.tmr == TMR_RST) begin
          d.coil = pat_tbl[4*q.phase +: 4];
          d.tmr  = TMR_W'(1);
        end else if (q.tmr == STEP_DLY) begin
          d.tmr = TMR_RST;
          if (q.phase == LAST_PHASE) begin
            d.phase = 3'd0;
            if (q.homing) begin
              d.home_cnt = q.home_cnt + IDX_W'(1);
              if (q.home_cnt == HOME_MOVES - IDX_W'(1)) begin
                d.homing  = 1'b0;
                d.present = START_POS;
                d.st      = ST_ARM;
              end
            end else begin
              d.present = q.dir_fwd ? q.present + IDX_W'(1)
                                    : q.present - IDX_W'(1);
              d.st      = ST_COMPARE;
            end
          end else begin
            d.phase = q.phase + 3'd1;
          end
        end else begin
          d.tmr = q.tmr + TMR_W'(1);
        end
      end
      // no interrupts exist, so the capture cannot be disturbed
      ST_ARM: begin
        if (rise) begin
          d.cnt = CNT_W'(1);
          d.st  = ST_PERIOD;
        end
      end
      ST_PERIOD: begin
        if (rise) begin
          d.period = q.cnt;
          d.cnt    = CNT_W'(1);
          d.st     = ST_HIGH;
        end else begin
          d.cnt = cnt_inc;
        end
      end
      ST_HIGH: begin
        if (fall) begin
          d.high      = q.cnt;
          d.div_start = 1'b1;
          d.st        = ST_CALC;
        end else begin
          d.cnt = cnt_inc;
        end
      end
      ST_CALC: begin
        if (div_done) begin
          d.target   = (quot > DIVIDEND_W'(FULL_SCALE)) ? FULL_SCALE
                                                        : quot[IDX_W-1:0];
          d.measured = 1'b1;
          d.st       = ST_COMPARE;
        end
      end
      ST_COMPARE: begin
        d.tmr   = TMR_RST;
        d.phase = 3'd0;
        if (q.target == q.present) begin
          d.st = ST_IDLE;
        end else begin
          d.dir_fwd = q.target > q.present;
          d.st      = ST_MOVE;
        end
      end
      ST_IDLE: begin
        if (q.tmr == IDLE_LAST) begin
          d.tmr      = TMR_RST;
          d.measured = 1'b0;
          d.st       = ST_ARM;
        end else begin
          d.tmr = q.tmr + TMR_W'(1);
        end
      end
      default: d.st = ST_ARM;
    endcase
  end

  // state register; reset starts the homing pass with coils off
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{st: ST_MOVE, pwm_s1: 1'b0, pwm_s2: 1'b0, pwm_s3: 1'b0,
             cnt: CNT_RST, period: CNT_RST, high: CNT_RST, target: START_POS,
             present: START_POS, measured: 1'b0, dir_fwd: 1'b0, homing: 1'b1,
             home_cnt: START_POS, phase: 3'd0, tmr: TMR_RST,
             coil: COIL_OFF, div_start: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign coil_drive_port_o = q.coil;
  assign present_index_o   = q.present;
  assign target_index_o    = q.target;
  assign measured_o        = q.measured;
  assign homing_o          = q.homing;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [DIVIDEND_W-1:0] exp_quot;
  logic [IDX_W-1:0]      exp_target;
  assign exp_quot   = (DIVIDEND_W'(q.high) * DIVIDEND_W'(PERCENT_MULT))
                      / DIVIDEND_W'((q.period == '0) ? CNT_W'(1) : q.period);
  assign exp_target = (exp_quot > DIVIDEND_W'(FULL_SCALE)) ? FULL_SCALE : exp_quot[IDX_W-1:0];

  sequence s_move_done;
    $changed(q.present) ##0 (q.st == ST_COMPARE);
  endsequence

  sequence s_idle_expired;
    (q.st == ST_IDLE) && (q.tmr == IDLE_LAST);
  endsequence

  a_reset_coils_off: assert property (
    @(posedge ref_clk_i) disable iff (1'b0)
    !$past(rst_n_i) |-> (coil_drive_port_o == COIL_OFF))
    else $error("coils not off after reset");

  a_fwd_pattern_order: assert property (
    ($changed(q.coil) && q.dir_fwd && !q.homing) |->
      ((q.coil == 4'ha && $past(q.coil) == 4'h0) || (q.coil == 4'h9 && $past(q.coil) == 4'ha) ||
       (q.coil == 4'h5 && $past(q.coil) == 4'h9) || (q.coil == 4'h6 && $past(q.coil) == 4'h5) ||
       (q.coil == 4'h0 && $past(q.coil) == 4'h6)))
    else $error("forward coil order broken");

  a_bwd_pattern_order: assert property (
    ($changed(q.coil) && !q.dir_fwd) |->
      ((q.coil == 4'ha && $past(q.coil) == 4'h0) || (q.coil == 4'h6 && $past(q.coil) == 4'ha) ||
       (q.coil == 4'h5 && $past(q.coil) == 4'h6) || (q.coil == 4'h9 && $past(q.coil) == 4'h5) ||
       (q.coil == 4'h0 && $past(q.coil) == 4'h9)))
    else $error("backward coil order broken");

  a_one_change_step: assert property (
    $changed(q.coil) |=> $stable(q.coil) [*1] ##1 $stable(q.coil))
    else $error("coil pattern changed twice within a step interval");

  a_home_to_zero: assert property (
    ($fell(q.homing)) |-> (q.present == START_POS && $past(q.home_cnt) == HOME_MOVES - 7'd1
                            && q.st == ST_ARM))
    else $error("homing did not end at index zero after 100 moves");

  a_target_formula: assert property (
    $rose(q.measured) |-> (q.target == exp_target))
    else $error("target differs from high*100/period");

  a_period_then_high: assert property (
    (q.st == ST_PERIOD && rise) |=> (q.st == ST_HIGH && q.cnt == 16'h0001))
    else $error("period capture did not rearm for falling edge");

  a_idle_remeasure: assert property (
    s_idle_expired |=> (q.st == ST_ARM && !q.measured))
    else $error("idle expiry did not remeasure");

  a_move_index_step: assert property (
    s_move_done |-> (q.coil == COIL_OFF &&
                     (q.dir_fwd ? q.present == $past(q.present) + 7'd1
                                : q.present == $past(q.present) - 7'd1)))
    else $error("index not stepped by one with coils off");

  a_dir_choice: assert property (
    (q.st == ST_COMPARE && q.target != q.present) |=>
      (q.st == ST_MOVE && q.dir_fwd == ($past(q.target) > $past(q.present))))
    else $error("wrong direction chosen");

  a_decide_measured: assert property (
    (q.st == ST_COMPARE) |-> q.measured)
    else $error("decision without a fresh measurement");

  a_arm_on_rise: assert property (
    (q.st == ST_ARM && rise) |=> (q.st == ST_PERIOD && q.cnt == 16'h0001))
    else $error("first rise did not start the period count");

  a_period_latch: assert property (
    (q.st == ST_PERIOD && rise) |=> (q.period == $past(q.cnt)))
    else $error("second rise did not latch the period count");

  a_flag_on_done: assert property (
    $rose(q.measured) |-> ($past(q.st) == ST_CALC && $past(div_done)))
    else $error("measured flag rose without a finished measurement");

  a_stale_cleared: assert property (
    (q.st == ST_ARM) |-> !q.measured)
    else $error("old measurement still flagged while a new one runs");

  a_move_ends_off: assert property (
    (q.st == ST_MOVE && q.phase == LAST_PHASE && q.tmr != TMR_RST) |-> (q.coil == COIL_OFF))
    else $error("move did not end with the coils off");

  a_idle_coils_off: assert property (
    (q.st == ST_IDLE) |-> (q.coil == COIL_OFF && q.target == q.present))
    else $error("idle entered with coils on or indices apart");

  a_target_in_range: assert property (
    q.target <= FULL_SCALE)
    else $error("target index beyond full scale");

  a_home_backward: assert property (
    q.homing |-> !q.dir_fwd)
    else $error("homing pass not moving backward");

  a_write_after_delay: assert property (
    ($changed(q.coil) && q.st == ST_MOVE) |-> ($past(q.tmr) == TMR_RST))
    else $error("coil pattern written before the delay ran out");

endmodule

// file: tb/pdsp_pwm_src.sv
/*
  pdsp_pwm_src: PWM source in front of the positioner.
  Assumes period_i above high_i; a new high time takes hold at a rise.
*/
`timescale 1ns/1ns
module pdsp_pwm_src (
  input  wire logic        clk_i,
  input  wire logic [15:0] period_i,
  input  wire logic [15:0] high_i,
  output logic             pwm_o
);
  logic [15:0] hi;

  // one period per pass, high time latched at the rise
  initial begin
    pwm_o = 1'b0;
    forever begin
      @(posedge clk_i);
      hi = high_i;
      #1 pwm_o = 1'b1;
      repeat (hi) @(posedge clk_i);
      #1 pwm_o = 1'b0;
      repeat (period_i - hi - 16'h0001) @(posedge clk_i);
    end
  end
endmodule

// file: tb/tb_pdsp_positioner.sv
/*
  tb_pdsp_positioner: drives PWM duties, notes expected coil patterns and
  indices, and checks them. Assumes short delay and idle parameters.
*/
`timescale 1ns/1ns
module tb_pdsp_positioner;
  import pdsp_pkg::*;
  localparam int unsigned DLY = 4;
  localparam int unsigned IDL = 20;
  localparam logic [15:0] PER = 16'h0190;
  localparam logic [19:0] FWD = 20'h0659a;
  localparam logic [19:0] REV = 20'h0956a;
  logic             ref_clk;
  logic             rst_n;
  logic             pwm;
  logic             meas;
  logic             homing;
  logic [3:0]       coil;
  logic [3:0]       last_coil;
  logic [IDX_W-1:0] pres;
  logic [IDX_W-1:0] targ;
  logic [15:0]      high;
  logic [3:0]       exp_q[$];
  int               n_mismatch;
  int               checked;
  int               cnt;
  int               cur;
  int               t0;

  pdsp_positioner #(.IDLE_LIMIT_CYC(IDL), .STEP_DLY_CYC(DLY)) i_dut (
    .ref_clk_i              (ref_clk),
    .rst_n_i                (rst_n),
    .capture_channel_input_i(pwm),
    .coil_drive_port_o      (coil),
    .present_index_o        (pres),
    .target_index_o         (targ),
    .measured_o             (meas),
    .homing_o               (homing)
  );

  pdsp_pwm_src i_src (
    .clk_i   (ref_clk),
    .period_i(PER),
    .high_i  (high),
    .pwm_o   (pwm)
  );

  // clock
  always #5 ref_clk = ~ref_clk;

  // shared comparison
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_coil(input logic [3:0] got, input logic [3:0] exp);
    cmp({4'h0, got}, {4'h0, exp});
  endtask

  task automatic chk_idx(input logic [6:0] got, input logic [6:0] exp);
    cmp({1'b0, got}, {1'b0, exp});
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // notes the five patterns of one position move
  task automatic push_move(input logic [19:0] seq);
    for (int i = 0; i < 5; i++) begin
      exp_q.push_back(seq[i*4 +: 4]);
    end
  endtask

  // waits for the next completed measurement, bounded
  task automatic wait_meas();
    int k;
    k = 0;
    while (meas !== 1'b0 && k < 30000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (meas !== 1'b1 && k < 30000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 30000) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // one duty setting: note the moves, then check target and index
  task automatic run(input int t);
    int prev;
    prev = cur;
    while (cur < t) begin
      push_move(FWD);
      cur++;
    end
    while (cur > t) begin
      push_move(REV);
      cur--;
    end
    high = 16'(4 * t + 2);
    wait_meas();
    chk_idx(targ, 7'(t));
    chk_idx(pres, 7'(prev));
    $display("test to position %0d done", t);
  endtask

  // monitor: every coil change against the oldest note, and its spacing unless it follows coils off;
  // sampled on the falling edge, clear of the edge that launches the coils
  always @(negedge ref_clk) begin
    cnt++;
    if (rst_n === 1'b1 && coil !== last_coil) begin
      if (exp_q.size() == 0) begin
        chk_coil(coil, last_coil);
      end else begin
        chk_coil(coil, exp_q.pop_front());
      end
      if (last_coil !== 4'h0) begin
        chk_idx(7'(cnt), 7'(DLY + 1));
      end
      cnt = 0;
    end
    last_coil = coil;
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end

  // main sequence
  initial begin
    ref_clk    = 1'b0;
    rst_n      = 1'b0;
    high       = 16'h0066;
    n_mismatch = 0;
    checked    = 0;
    cnt        = 0;
    cur        = 0;
    last_coil  = 4'h0;
    t0         = $urandom(45);
    repeat (4) @(posedge ref_clk);
    #1;
    chk_coil(coil, 4'h0);
    chk_idx(pres, 7'h00);
    chk_idx({6'h00, homing}, 7'h01);
    for (int i = 0; i < 100; i++) begin
      push_move(REV);
    end
    rst_n = 1'b1;
    t0 = 1 + ($urandom % 98);
    run(t0);
    chk_idx({6'h00, homing}, 7'h00);
    run(t0);
    run(99);
    run(0);
    run(3);
    run(3);
    chk_idx(7'(exp_q.size()), 7'h00);
    test_done();
  end
endmodule
